/* File: common/psrc_pkg.sv */
package psrc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Clock rate in MHz
  localparam int unsigned CLK_MHZ = 250;
  // Debounce interval in ms
  localparam int unsigned DEBOUNCE_MS = 10;
  // Delay before a pin-triggered reset in ms
  localparam int unsigned RESET_DELAY_MS = 200;
  // Soft reset pulse width in ms
  localparam int unsigned SOFT_PULSE_MS = 10;
  // Derived cycle counts
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SOFT_PULSE_CYC = SOFT_PULSE_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Pin-function codes
  // ---------------------------------------------------------------
  localparam logic [3:0] PFS_ONOFF_HIGH = 4'h0;
  localparam logic [3:0] PFS_ONOFF_LOW = 4'h1;
  localparam logic [3:0] PFS_AON_RISE = 4'h2;
  localparam logic [3:0] PFS_AON_FALL = 4'h3;
  localparam logic [3:0] PFS_CR_HIGH = 4'h4;

  // ---------------------------------------------------------------
  // Power command codes
  // ---------------------------------------------------------------
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_POWER_OFF = 2'h1;
  localparam logic [1:0] CMD_SEAL = 2'h2;
  localparam logic [1:0] CMD_BATTERY_RECOVERY = 2'h3;

  // Power states, one-hot
  typedef enum logic [4:0] {
    PST_BOOT = 5'h01,
    PST_ON = 5'h02,
    PST_OFF = 5'h04,
    PST_SEAL = 5'h08,
    PST_RECOVERY = 5'h10
  } psrc_state_t;

  // Outputs that leave together
  typedef struct packed {
    logic system_rail_en;
    logic aux_linear_regulator_en;
    logic reset_n;
    logic hard_reset;
    logic soft_reset_restore_defaults;
  } psrc_out_t;

endpackage

/* File: sim/psrc_partner.sv */
`timescale 1ns/1ps
// Far-side model: two push buttons, a charger source and a command host
module psrc_partner (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic key_a,
  input wire logic key_b,
  input wire logic chg,
  input wire logic cmd_go,
  input wire logic [1:0] cmd_code,
  // Pins toward the block
  output logic power_func_in_a = 1'b0,
  output logic power_func_in_b = 1'b0,
  output logic charger_input = 1'b0,
  output logic power_command_we = 1'b0,
  output logic [1:0] power_command_reg = 2'h0
);
  // ---------------------------------------------------------------
  // Pads
  // ---------------------------------------------------------------
  // Buttons and charger are levels, passed on one edge late like a pad
  always @(posedge sys_clk) begin
    power_func_in_a <= key_a;
    power_func_in_b <= key_b;
    charger_input <= chg;
  end
  // ---------------------------------------------------------------
  // Command host
  // ---------------------------------------------------------------
  // one-cycle command write
  // The code is only meaningful with the strobe, so it wanders otherwise
  always @(posedge sys_clk) begin
    power_command_we <= cmd_go;
    power_command_reg <= cmd_go ? cmd_code : ~power_command_reg;
  end
endmodule

/* File: sim/test_power_switch_reset_control.sv */
`timescale 1ns/1ps
// Directed bench for the power switch and reset controller
module test_power_switch_reset_control;
  // Shortened counts keep the run to a few hundred cycles
  localparam int unsigned DEB = 4;
  localparam int unsigned DLY = 8;
  localparam int unsigned PUL = 10;
  // Stimulus and observed signals
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] pfs = psrc_pkg::PFS_AON_RISE;
  logic hrv = 1'b0;
  logic pol = 1'b0;
  logic aseq = 1'b0;
  logic areq = 1'b0;
  logic ishut = 1'b0;
  logic key_a = 1'b0;
  logic key_b = 1'b0;
  logic chg = 1'b0;
  logic cmd_go = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic pa, pb, ci, we, rail, aux, rstn_out, hard, restore;
  logic [1:0] creg;
  logic [4:0] st;
  logic [1:0] cmd_t [4] = '{psrc_pkg::CMD_POWER_OFF, psrc_pkg::CMD_POWER_OFF,
    psrc_pkg::CMD_SEAL, psrc_pkg::CMD_BATTERY_RECOVERY};
  logic [4:0] st_t [4] = '{psrc_pkg::PST_OFF, psrc_pkg::PST_OFF, psrc_pkg::PST_SEAL,
    psrc_pkg::PST_RECOVERY};
  logic [3:0] aux_t = 4'h3;
  int failures = 0;
  int n_checks = 0;
  int n;

  psrc_partner far (.sys_clk(sys_clk), .key_a(key_a), .key_b(key_b), .chg(chg),
    .cmd_go(cmd_go), .cmd_code(cmd_code), .power_func_in_a(pa), .power_func_in_b(pb),
    .charger_input(ci), .power_command_we(we), .power_command_reg(creg));

  psrc_power_switch #(.DEBOUNCE_CYC(DEB), .RESET_DELAY_CYC(DLY), .SOFT_PULSE_CYC(PUL)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .power_func_in_a(pa), .power_func_in_b(pb),
    .charger_input(ci), .pin_function_select(pfs), .harvester_enable(hrv),
    .soft_reset_reg_policy(pol), .aux_linear_reg_sequence(aseq), .aux_on_request(areq),
    .power_command_we(we), .power_command_reg(creg), .internal_shutdown(ishut),
    .system_rail_en(rail), .aux_linear_regulator_en(aux), .reset_n(rstn_out),
    .hard_reset(hard), .soft_reset_restore_defaults(restore), .power_state(st));

  // 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a state, then compare it
  task automatic see(input logic [4:0] s);
    n = 0;
    while (st !== s && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(st, s);
  endtask
  // Bounded count of cycles until a signal reaches a level
  task automatic count_to(ref logic sig, input logic lvl);
    n = 0;
    while (sig !== lvl && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(sig, lvl);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // The strobe drops a full cycle before the next write may start
  task automatic send_cmd(input logic [1:0] c);
    cmd_code <= c;
    cmd_go <= 1'b1;
    @(posedge sys_clk);
    cmd_go <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic close_out;
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    see(psrc_pkg::PST_SEAL);
    chk({rail, aux}, 5'h0);
    // Each command from ON, with the aux keep-alive variants
    for (int i = 0; i < 4; i++) begin
      chg <= 1'b1;
      see(psrc_pkg::PST_ON);
      chk(rail, 1'b1);
      chg <= 1'b0;
      aseq <= (i == 0);
      areq <= (i == 1) || (i == 2);
      cyc(DEB + 2);
      send_cmd(cmd_t[i]);
      see(st_t[i]);
      chk({rail, aux}, {4'h0, aux_t[i]});
    end
    // A command outside ON is ignored
    send_cmd(psrc_pkg::CMD_POWER_OFF);
    cyc(3);
    chk(st, psrc_pkg::PST_RECOVERY);
    // Rising edge on pin a gives a delayed hard reset
    chg <= 1'b1;
    see(psrc_pkg::PST_ON);
    key_a <= 1'b1;
    count_to(hard, 1'b1);
    chk(n >= DLY && n <= DLY + DEB + 4, 1'b1);
    cyc(1);
    chk(hard, 1'b0);
    see(psrc_pkg::PST_ON);
    // Falling edge on pin b gives a delayed soft reset
    chg <= 1'b0;
    pfs <= psrc_pkg::PFS_AON_FALL;
    key_b <= 1'b1;
    pol <= 1'b1;
    cyc(DEB + 4);
    key_b <= 1'b0;
    count_to(rstn_out, 1'b0);
    chk(n >= DLY, 1'b1);
    count_to(rstn_out, 1'b1);
    chk(n >= PUL, 1'b1);
    chk(restore, 1'b1);
    chk(st, psrc_pkg::PST_ON);
    // Internal condition shuts down
    ishut <= 1'b1;
    count_to(rail, 1'b0);
    ishut <= 1'b0;
    chg <= 1'b1;
    see(psrc_pkg::PST_ON);
    chg <= 1'b0;
    key_b <= 1'b1;
    cyc(DEB + 4);
    // Active-high on/off: a short glitch is filtered out
    pfs <= psrc_pkg::PFS_ONOFF_HIGH;
    pol <= 1'b0;
    key_a <= 1'b0;
    cyc(2);
    key_a <= 1'b1;
    cyc(DEB + 6);
    chk(st, psrc_pkg::PST_ON);
    key_a <= 1'b0;
    see(psrc_pkg::PST_OFF);
    key_a <= 1'b1;
    see(psrc_pkg::PST_ON);
    key_b <= 1'b0;
    count_to(rstn_out, 1'b0);
    key_b <= 1'b1;
    count_to(rstn_out, 1'b1);
    chk(restore, 1'b0);
    // Active-low on/off with harvester goes to recovery; pin a is parked
    // low under an always-on code first, so the code switch is no press
    pfs <= psrc_pkg::PFS_AON_RISE;
    key_a <= 1'b0;
    cyc(DEB + 4);
    hrv <= 1'b1;
    pfs <= psrc_pkg::PFS_ONOFF_LOW;
    cyc(DEB + 4);
    chk(st, psrc_pkg::PST_ON);
    key_a <= 1'b1;
    see(psrc_pkg::PST_RECOVERY);
    key_a <= 1'b0;
    see(psrc_pkg::PST_ON);
    // Pin b high during charger insertion
    pfs <= psrc_pkg::PFS_CR_HIGH;
    cyc(DEB + 4);
    chg <= 1'b1;
    count_to(rstn_out, 1'b0);
    chk(n >= DLY, 1'b1);
    close_out;
  end

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    cyc(3000);
    failures++;
    close_out;
  end
endmodule

/* File: verilog/psrc_debounce.sv */
`timescale 1ns/1ps
// Stable-level filter: the output follows the input only after the input
// has held one level for CYCLES consecutive clocks.
module psrc_debounce #(
  parameter int unsigned CYCLES = psrc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw and qualified level
  input wire logic raw,
  output logic level
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt;
    logic level;
  } psrc_deb_t;

  psrc_deb_t st;
  psrc_deb_t next_st;

  // Restart the count whenever the input agrees with the output; a glitch never qualifies
  always_comb begin
    next_st = st;
    if (raw == st.level) begin
      next_st.cnt = 32'h0;
    end else if (st.cnt >= 32'(CYCLES - 1)) begin
      next_st.level = raw;
      next_st.cnt = 32'h0;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  // Register the state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

/* File: verilog/psrc_power_switch.sv */
`timescale 1ns/1ps
//
// Contract
// - OFF: rail off, aux kept if needed
// - SEAL: everything off, lowest consumption
// - Requests from pins, commands, internal conditions
// - Soft reset: 10ms low pulse, policy
// - Hard reset restarts full power-on sequence
// - Cold boot: ON with charger, else SEAL or recovery by harvester
// - ON: commands enter OFF, SEAL, recovery
// - Pin shutdown: OFF or recovery by config
// - Charger or key pin restores power
// - ON keeps system rail enabled
// - Code 0000: high on/off, low reset
// - Code 0001: low on/off, low reset
// - Code 0010: rising edges, delayed resets
// - Code 0011: falling edges, delayed resets
// - Code 0100: pin b high, insertion reset
module psrc_power_switch #(
  parameter int unsigned DEBOUNCE_CYC = psrc_pkg::DEBOUNCE_CYC,
  parameter int unsigned RESET_DELAY_CYC = psrc_pkg::RESET_DELAY_CYC,
  parameter int unsigned SOFT_PULSE_CYC = psrc_pkg::SOFT_PULSE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pins
  input wire logic power_func_in_a,
  input wire logic power_func_in_b,
  input wire logic charger_input,
  // Configuration
  input wire logic [3:0] pin_function_select,
  input wire logic harvester_enable,
  input wire logic soft_reset_reg_policy,
  input wire logic aux_linear_reg_sequence,
  input wire logic aux_on_request,
  // Power command register write, one-cycle strobe
  input wire logic power_command_we,
  input wire logic [1:0] power_command_reg,
  // Internal qualifying shutdown condition
  input wire logic internal_shutdown,
  // Outputs
  output logic system_rail_en,
  output logic aux_linear_regulator_en,
  output logic reset_n,
  output logic hard_reset,
  output logic soft_reset_restore_defaults,
  output logic [4:0] power_state
);

  // ---------------------------------------------------------------
  // Debounced pins
  // ---------------------------------------------------------------
  logic pin_a;
  logic pin_b;

  psrc_debounce #(.CYCLES(DEBOUNCE_CYC)) u_deb_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw(power_func_in_a),
    .level(pin_a)
  );
  psrc_debounce #(.CYCLES(DEBOUNCE_CYC)) u_deb_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw(power_func_in_b),
    .level(pin_b)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psrc_pkg::psrc_state_t fsm;
    psrc_pkg::psrc_out_t out;
    logic pin_a_q;       // Previous qualified levels, for edges
    logic pin_b_q;
    logic chg_q;         // Previous charger level
    logic hard_pend;     // Delayed hard reset armed
    logic soft_pend;     // Delayed soft reset armed
    logic [31:0] dly;    // 200ms delay counter
    logic [31:0] pulse;  // Reset pulse counter
  } psrc_st_t;

  psrc_st_t st;
  psrc_st_t next_st;

  // Always-on codes block pin shutdown
  function automatic logic is_aon(input logic [3:0] code);
    return code == psrc_pkg::PFS_AON_RISE || code == psrc_pkg::PFS_AON_FALL
        || code == psrc_pkg::PFS_CR_HIGH;
  endfunction

  logic on_level;
  logic chg_rise;
  logic soft_req;
  logic hard_arm;
  logic soft_arm;

  // Pin decoding per pin-function code
  always_comb begin
    chg_rise = charger_input && !st.chg_q;
    hard_arm = 1'b0;
    soft_arm = 1'b0;
    soft_req = 1'b0;
    on_level = 1'b1;
    unique case (pin_function_select)
      psrc_pkg::PFS_ONOFF_HIGH: begin
        on_level = pin_a;
        soft_req = !pin_b && st.pin_b_q;
      end
      psrc_pkg::PFS_ONOFF_LOW: begin
        on_level = !pin_a;
        soft_req = !pin_b && st.pin_b_q;
      end
      psrc_pkg::PFS_AON_RISE: begin
        hard_arm = pin_a && !st.pin_a_q;
        soft_arm = pin_b && !st.pin_b_q;
      end
      psrc_pkg::PFS_AON_FALL: begin
        hard_arm = !pin_a && st.pin_a_q;
        soft_arm = !pin_b && st.pin_b_q;
      end
      psrc_pkg::PFS_CR_HIGH: begin
        hard_arm = chg_rise && pin_a;
        soft_arm = chg_rise && pin_b;
      end
      // Codes outside this block read no pin; on_level stays high, so OFF, SEAL and recovery wake to ON unless internal_shutdown is high
      default: begin
        on_level = 1'b1;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.pin_a_q = pin_a;
    next_st.pin_b_q = pin_b;
    next_st.chg_q = charger_input;
    next_st.out.hard_reset = 1'b0;
    // Reset pulse countdown
    if (st.pulse != 32'h0) begin
      next_st.pulse = st.pulse - 32'h1;
    end else begin
      next_st.out.reset_n = 1'b1;
    end
    if (hard_arm || soft_arm) begin
      next_st.hard_pend = st.hard_pend || hard_arm;
      next_st.soft_pend = st.soft_pend || soft_arm;
      next_st.dly = 32'(RESET_DELAY_CYC - 1);
    end else if ((st.hard_pend || st.soft_pend) && st.dly != 32'h0) begin
      next_st.dly = st.dly - 32'h1;
    end else if (st.hard_pend) begin
      // Hard reset pulse wins over soft
      next_st.out.hard_reset = 1'b1;
      next_st.hard_pend = 1'b0;
      next_st.soft_pend = 1'b0;
      next_st.fsm = psrc_pkg::PST_BOOT;
    end else if (st.soft_pend) begin
      // Delay ran out; the pulse itself is raised below, only while ON
      next_st.soft_pend = 1'b0;
    end
    if ((soft_req || (st.soft_pend && !st.hard_pend && !hard_arm && !soft_arm
         && st.dly == 32'h0)) && st.fsm == psrc_pkg::PST_ON) begin
      next_st.out.reset_n = 1'b0;
      next_st.pulse = 32'(SOFT_PULSE_CYC - 1);
      next_st.out.soft_reset_restore_defaults = soft_reset_reg_policy;
    end
    unique case (st.fsm)
      psrc_pkg::PST_BOOT: begin
        if (charger_input) begin
          next_st.fsm = psrc_pkg::PST_ON;
        end else begin
          next_st.fsm = harvester_enable ? psrc_pkg::PST_RECOVERY : psrc_pkg::PST_SEAL;
        end
      end
      psrc_pkg::PST_ON: begin
        if (power_command_we && power_command_reg == psrc_pkg::CMD_POWER_OFF) begin
          next_st.fsm = psrc_pkg::PST_OFF;
        end else if (power_command_we && power_command_reg == psrc_pkg::CMD_SEAL) begin
          next_st.fsm = psrc_pkg::PST_SEAL;
        end else if (power_command_we
                     && power_command_reg == psrc_pkg::CMD_BATTERY_RECOVERY) begin
          next_st.fsm = psrc_pkg::PST_RECOVERY;
        end else if ((!on_level && !is_aon(pin_function_select)) || internal_shutdown) begin
          next_st.fsm = harvester_enable ? psrc_pkg::PST_RECOVERY : psrc_pkg::PST_OFF;
        end
      end
      psrc_pkg::PST_OFF, psrc_pkg::PST_SEAL, psrc_pkg::PST_RECOVERY: begin
        if (chg_rise || charger_input
            || (on_level && !is_aon(pin_function_select) && !internal_shutdown)) begin
          next_st.fsm = psrc_pkg::PST_ON;
        end
      end
      default: begin
        next_st.fsm = psrc_pkg::PST_BOOT;
      end
    endcase
    next_st.out.system_rail_en = (next_st.fsm == psrc_pkg::PST_ON);
    if (next_st.fsm == psrc_pkg::PST_ON) begin
      next_st.out.aux_linear_regulator_en = aux_on_request || aux_linear_reg_sequence;
    end else if (next_st.fsm == psrc_pkg::PST_OFF) begin
      // Kept by the sequence bit, or because it was already on at entry
      next_st.out.aux_linear_regulator_en = aux_linear_reg_sequence
          || st.out.aux_linear_regulator_en;
    end else begin
      next_st.out.aux_linear_regulator_en = 1'b0;
    end
  end

  // Register all state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{fsm: psrc_pkg::PST_BOOT, out: '{reset_n: 1'b1, default: 1'b0},
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign system_rail_en = st.out.system_rail_en;
  assign aux_linear_regulator_en = st.out.aux_linear_regulator_en;
  assign reset_n = st.out.reset_n;
  assign hard_reset = st.out.hard_reset;
  assign soft_reset_restore_defaults = st.out.soft_reset_restore_defaults;
  assign power_state = st.fsm;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_SEAL_ALL_OFF: assert property (
    st.fsm == psrc_pkg::PST_SEAL |-> !system_rail_en && !aux_linear_regulator_en)
    else $error("Seal state with an output on");
  AST_RAIL_ON: assert property (
    st.fsm == psrc_pkg::PST_ON |-> system_rail_en)
    else $error("Rail off while on");
  AST_OFF_RAIL: assert property (
    st.fsm == psrc_pkg::PST_OFF |-> !system_rail_en)
    else $error("Rail on in off state");
  AST_OFF_AUX_SEQ: assert property (
    st.fsm == psrc_pkg::PST_OFF && $past(aux_linear_reg_sequence) |-> aux_linear_regulator_en)
    else $error("Aux regulator dropped despite always-on sequence");
  AST_CMD_OFF: assert property (
    st.fsm == psrc_pkg::PST_ON && power_command_we
    && power_command_reg == psrc_pkg::CMD_POWER_OFF |=> st.fsm == psrc_pkg::PST_OFF)
    else $error("Power-off command ignored");
  AST_CMD_SEAL: assert property (
    st.fsm == psrc_pkg::PST_ON && power_command_we
    && power_command_reg == psrc_pkg::CMD_SEAL |=> st.fsm == psrc_pkg::PST_SEAL)
    else $error("Seal command ignored");
  AST_CMD_RECOVERY: assert property (
    st.fsm == psrc_pkg::PST_ON && power_command_we
    && power_command_reg == psrc_pkg::CMD_BATTERY_RECOVERY
    |=> st.fsm == psrc_pkg::PST_RECOVERY)
    else $error("Recovery command ignored");
  AST_BOOT: assert property (
    st.fsm == psrc_pkg::PST_BOOT && !charger_input |=>
    st.fsm == ($past(harvester_enable) ? psrc_pkg::PST_RECOVERY : psrc_pkg::PST_SEAL))
    else $error("Wrong cold boot state");
  AST_WAKE: assert property (
    st.fsm == psrc_pkg::PST_SEAL && charger_input |=> st.fsm == psrc_pkg::PST_ON)
    else $error("Charger did not wake");
  AST_PULSE: assert property (
    $fell(reset_n) |-> !reset_n [*8])
    else $error("Soft reset pulse too short");

  COV_SOFT: cover property ($fell(reset_n));
  COV_HARD: cover property (hard_reset);
  COV_SEAL: cover property (st.fsm == psrc_pkg::PST_SEAL);
  COV_WAKE: cover property ($rose(system_rail_en));

endmodule
